// file: src/cpg_pkg.sv
// constants, carrier types and states of the converter protection and power-good block
//
// What this block does
// - discharge is governed by a control bit that resets to enabled
// - discharge acts on enable pin low, switching off, thermal shutdown or either lockout
// - discharge stays unavailable until the converter was enabled once after power up
// - supply below low threshold locks out: switching stops, discharge on if enabled
// - supply above high threshold locks out: switching stops, discharge on if enabled
// - high lockout ends below release threshold and restarts with fresh soft start
// - high-side limit turns high side off, low side on, until low-side limit cleared
// - retry control bit picks retry protection when 1, plain current limit when 0
// - retry: 32 consecutive limited cycles halt switching 128 cycles, then soft start
// - retry trip sets retry event flag and holds good output low until regulating
// - detect, pause and soft-start attempt repeat while the overload persists
// - status read clears retry event flag only when no overload is present
// - limit mode: four or more consecutive limited cycles set current limit flag
// - status read clears current limit flag only when no overload is present
// - good pin is open drain when primary, soft-start-done input when secondary
// - window comparator flags out of window below 95 or above 105 percent
// - window result deglitched about 40 us, delaying the rising good indication
// - with blanking set, window result is ignored while a voltage ramp runs
// - good output forced low in shutdown, disabled, low lockout and soft start
package cpg_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] STATE_OFFSET  = 8'h08;

  // control field positions and reset value
  localparam int CTRL_DISCH_BIT   = 0;
  localparam int CTRL_SWITCHING_ENABLE_BIT    = 1;
  localparam int CTRL_RETRY_BIT   = 2;
  localparam int CTRL_BLANK_BIT   = 3;
  localparam int CTRL_SECOND_BIT  = 4;
  localparam logic [4:0] CTRL_RESET = 5'h03;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 100;
  localparam int DEGLITCH_NS     = 40000;
  localparam int DEGLITCH_CYCLES = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAUSE_CYCLES    = 128;
  localparam int TRIP_CYCLES     = 32;
  localparam int FLAG_CYCLES     = 4;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic second;  // secondary device in a stack
    logic blank;   // good_blank_during_ramp
    logic retry;   // retry_protect_enable
    logic switching_enable;    // switching_enable
    logic disch;   // output_discharge_enable
  } cpg_ctrl_type;

  typedef struct packed {
    logic en_pin;        // enable pin level
    logic supply_low;    // supply below 2.5 V
    logic supply_high;   // supply above 6.3 V
    logic supply_ok_hi;  // supply below 6.2 V
    logic hs_over;       // high-side current above limit
    logic ls_below;      // inductor current below low-side limit
    logic out_window;    // output below 95 or above 105 percent
    logic thermal_shut;  // thermal shutdown active
  } cpg_sense_type;

  typedef struct packed {
    logic switching_run;
    logic hs_allow;
    logic ls_force;
    logic softstart_go;
    logic discharge_on;
  } cpg_drive_type;

  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_SOFT  = 2'b01,
    ST_RUN   = 2'b11,
    ST_PAUSE = 2'b10
  } cpg_state_type;

endpackage

// file: src/cpg_top.sv
// converter fault supervision, current limit, discharge and power-good logic
`timescale 1ns/10ps

module cpg_top #(
  parameter int PAUSE_CYCLES    = cpg_pkg::PAUSE_CYCLES,
  parameter int TRIP_CYCLES     = cpg_pkg::TRIP_CYCLES,
  parameter int FLAG_CYCLES     = cpg_pkg::FLAG_CYCLES,
  parameter int DEGLITCH_CYCLES = cpg_pkg::DEGLITCH_CYCLES
) (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  // ahb-lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  // analog comparators and pins
  input  wire cpg_pkg::cpg_sense_type sense,
  // converter core, same clock
  input  wire logic                   sw_tick,
  input  wire logic                   softstart_done,
  input  wire logic                   ramp_active,
  // power stage
  output cpg_pkg::cpg_drive_type      drive,
  output logic                        ccm_mode,
  // good pin, open drain
  input  wire logic                   good_in,
  output logic                        good_out,
  output logic                        good_oe_n
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  cpg_pkg::cpg_sense_type sense_meta_r;
  cpg_pkg::cpg_sense_type s;
  logic                   good_meta_r;
  logic                   good_sync_r;

  // two flops on every pin-side input
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sense_meta_r <= '0;
      s            <= '0;
      good_meta_r  <= 1'b0;
      good_sync_r  <= 1'b0;
    end else begin
      sense_meta_r <= sense;
      s            <= sense_meta_r;
      good_meta_r  <= good_in;
      good_sync_r  <= good_meta_r;
    end
  end

  // ****************************************************************
  // registers and bus slave
  // ****************************************************************
  cpg_pkg::cpg_ctrl_type ctrl_r;
  cpg_pkg::cpg_state_type state_r;
  cpg_pkg::cpg_state_type state_nxt;
  logic       wr_pend_r;
  logic [7:0] wr_addr_r;
  logic       retry_flag_r;
  logic       current_limit_flag_flag_r;
  logic       supply_high_lockout_r;
  logic       addr_phase;
  logic       rd_status;

  function automatic logic reg_hit(input logic [31:0] addr, input logic [7:0] off);
    reg_hit = (addr[31:8] == 24'h000000) && (addr[7:0] == off);
  endfunction

  assign addr_phase = hsel && htrans[1] && hready;
  assign rd_status  = addr_phase && !hwrite && reg_hit(haddr, cpg_pkg::STATUS_OFFSET);

  // zero-wait slave, always okay
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // write address capture for the data phase
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= addr_phase && hwrite && (haddr[31:8] == 24'h000000);
      wr_addr_r <= haddr[7:0];
    end
  end

  // control register, only the control word is writable
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= cpg_pkg::CTRL_RESET;
    end else if (wr_pend_r && wr_addr_r == cpg_pkg::CTRL_OFFSET) begin
      ctrl_r <= hwdata[4:0];
    end
  end

  // read data latched in the address phase, unmapped reads zero
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase && !hwrite) begin
      if (reg_hit(haddr, cpg_pkg::CTRL_OFFSET))
        hrdata <= {27'h0000000, ctrl_r};
      else if (reg_hit(haddr, cpg_pkg::STATUS_OFFSET))
        hrdata <= {30'h00000000, current_limit_flag_flag_r, retry_flag_r};
      else if (reg_hit(haddr, cpg_pkg::STATE_OFFSET))
        hrdata <= {25'h0000000, s.thermal_shut, supply_high_lockout_r, s.supply_low, ccm_mode, good_oe_n, state_r};
      else
        hrdata <= 32'h00000000;
    end
  end

  // ****************************************************************
  // lockouts and enable
  // ****************************************************************
  logic en_ok;
  logic armed_r;

  // high lockout latch, released below lower threshold
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      supply_high_lockout_r <= 1'b0;
    else if (s.supply_high)
      supply_high_lockout_r <= 1'b1;
    else if (s.supply_ok_hi)
      supply_high_lockout_r <= 1'b0;
  end

  // low lockout and others block switching
  assign en_ok = s.en_pin && ctrl_r.switching_enable && !s.supply_low && !supply_high_lockout_r && !s.thermal_shut;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      armed_r <= 1'b0;
    else if (s.en_pin && ctrl_r.switching_enable)
      armed_r <= 1'b1;
  end

  // ****************************************************************
  // current limit and consecutive cycle counting
  // ****************************************************************
  logic       hs_block_r;
  logic       hs_block_nxt;
  logic       cycle_lim_r;
  logic       lim_now;
  logic [5:0] consec_r;
  logic       trip;
  logic       current_limit_flag_set;
  logic       overload;
  logic       switching;

  assign switching = (state_r == cpg_pkg::ST_SOFT) || (state_r == cpg_pkg::ST_RUN);
  assign lim_now   = cycle_lim_r || s.hs_over;

  // hold high side off until current below low-side limit
  always_comb begin
    hs_block_nxt = hs_block_r;
    if (s.hs_over)
      hs_block_nxt = 1'b1;
    else if (s.ls_below)
      hs_block_nxt = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      hs_block_r <= 1'b0;
    else
      hs_block_r <= hs_block_nxt;
  end

  // limit seen within the current switching cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      cycle_lim_r <= 1'b0;
    else if (sw_tick)
      cycle_lim_r <= s.hs_over;
    else if (s.hs_over)
      cycle_lim_r <= 1'b1;
  end

  // trip on the 32nd limited cycle, retry bit selects mode
  assign trip     = ctrl_r.retry && switching && sw_tick && lim_now &&
                    (consec_r == 6'(TRIP_CYCLES - 1));
  // four or more limited cycles in limit mode
  assign current_limit_flag_set = !ctrl_r.retry && sw_tick && lim_now && (consec_r >= 6'(FLAG_CYCLES - 1));
  assign overload = lim_now || (consec_r != 6'h00) || (state_r == cpg_pkg::ST_PAUSE);

  // consecutive limited cycle counter, saturating
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      consec_r <= 6'h00;
    else if (!switching || trip)
      consec_r <= 6'h00;
    else if (sw_tick)
      consec_r <= lim_now ? ((consec_r == 6'h3f) ? consec_r : consec_r + 6'h01) : 6'h00;
  end

  // ****************************************************************
  // status flags, set wins over read clear
  // ****************************************************************
  // retry event flag, cleared by read when no overload
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      retry_flag_r <= 1'b0;
    else if (trip)
      retry_flag_r <= 1'b1;
    else if (rd_status && !overload)
      retry_flag_r <= 1'b0;
  end

  // limit flag, cleared by read when no overload
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      current_limit_flag_flag_r <= 1'b0;
    else if (current_limit_flag_set)
      current_limit_flag_flag_r <= 1'b1;
    else if (rd_status && !overload)
      current_limit_flag_flag_r <= 1'b0;
  end

  // ****************************************************************
  // sequencer and pause counter
  // ****************************************************************
  logic [7:0] pause_cnt_r;
  logic       pause_done;

  assign pause_done = sw_tick && (pause_cnt_r == 8'(PAUSE_CYCLES - 1));

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      pause_cnt_r <= 8'h00;
    else if (state_r != cpg_pkg::ST_PAUSE)
      pause_cnt_r <= 8'h00;
    else if (sw_tick)
      pause_cnt_r <= pause_cnt_r + 8'h01;
  end

  // trip, pause and soft start repeat while overloaded
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cpg_pkg::ST_OFF: begin
        if (en_ok)
          state_nxt = cpg_pkg::ST_SOFT;
      end
      cpg_pkg::ST_SOFT: begin
        if (!en_ok)
          state_nxt = cpg_pkg::ST_OFF;
        else if (trip)
          state_nxt = cpg_pkg::ST_PAUSE;
        else if (softstart_done)
          state_nxt = cpg_pkg::ST_RUN;
      end
      cpg_pkg::ST_RUN: begin
        if (!en_ok)
          state_nxt = cpg_pkg::ST_OFF;
        else if (trip)
          state_nxt = cpg_pkg::ST_PAUSE;
      end
      cpg_pkg::ST_PAUSE: begin
        if (!en_ok)
          state_nxt = cpg_pkg::ST_OFF;
        else if (pause_done)
          state_nxt = cpg_pkg::ST_SOFT;
      end
      default: state_nxt = cpg_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      state_r <= cpg_pkg::ST_OFF;
    else
      state_r <= state_nxt;
  end

  // ****************************************************************
  // power stage drive
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      drive <= '0;
    end else begin
      drive.switching_run <= switching;
      // high side off, low side on while blocked
      drive.hs_allow      <= switching && !hs_block_nxt;
      drive.ls_force      <= switching && hs_block_nxt;
      // fresh soft start on each entry
      drive.softstart_go  <= (state_nxt == cpg_pkg::ST_SOFT) && (state_r != cpg_pkg::ST_SOFT);
      // discharge conditions gated by enable bit and arming
      drive.discharge_on  <= ctrl_r.disch && armed_r &&
                             (!s.en_pin || !ctrl_r.switching_enable || s.thermal_shut || s.supply_low || supply_high_lockout_r);
    end
  end

  // ****************************************************************
  // power good
  // ****************************************************************
  logic       good_raw;
  logic [8:0] glitch_cnt_r;
  logic       filt_r;
  logic       forced_low;

  // out-of-window from comparator, blanked during ramps
  assign good_raw   = !s.out_window || (ctrl_r.blank && ramp_active);
  // low in shutdown, disabled, lockout, soft start or pause
  assign forced_low = !en_ok || (state_r != cpg_pkg::ST_RUN);

  // rising edge waits a full deglitch interval
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      glitch_cnt_r <= 9'h000;
      filt_r       <= 1'b0;
    end else if (forced_low || !good_raw) begin
      glitch_cnt_r <= 9'h000;
      filt_r       <= 1'b0;
    end else if (!filt_r) begin
      glitch_cnt_r <= glitch_cnt_r + 9'h001;
      filt_r       <= (glitch_cnt_r == 9'(DEGLITCH_CYCLES - 1));
    end
  end

  // primary drives window status, secondary releases after soft start
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      good_oe_n <= 1'b0;
      good_out  <= 1'b0;
    end else begin
      good_out <= 1'b0;
      if (ctrl_r.second)
        good_oe_n <= !forced_low;
      else
        good_oe_n <= !forced_low && filt_r && good_raw;
    end
  end

  // secondary moves to continuous conduction once the shared pin rises
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      ccm_mode <= 1'b0;
    else if (!ctrl_r.second)
      ccm_mode <= 1'b1;
    else if (state_r == cpg_pkg::ST_OFF)
      ccm_mode <= 1'b0;
    else if (good_sync_r && state_r == cpg_pkg::ST_RUN)
      ccm_mode <= 1'b1;
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_DISCH_ACTIVE: assert property (ctrl_r.disch && armed_r && s.supply_low |=> drive.discharge_on)
    else $error("discharge not on during low lockout");
  AST_DISCH_UNARMED: assert property (!armed_r |=> !drive.discharge_on)
    else $error("discharge before first enable");
  AST_LOW_STOP: assert property (s.supply_low |=> ##1 !drive.switching_run)
    else $error("switching during low lockout");
  AST_HIGH_STOP: assert property (supply_high_lockout_r |=> ##1 !drive.switching_run)
    else $error("switching during high lockout");
  AST_RESTART: assert property (state_r == cpg_pkg::ST_OFF && en_ok |=> drive.softstart_go)
    else $error("no soft start after release");
  AST_HS_OFF: assert property (s.hs_over |=> !drive.hs_allow && (drive.ls_force == $past(switching)))
    else $error("high side not blocked on limit");
  AST_TRIP_PAUSE: assert property (trip |=> (state_r == cpg_pkg::ST_PAUSE)[*4] ##1 retry_flag_r)
    else $error("retry trip did not pause");
  AST_PAUSE_END: assert property (state_r == cpg_pkg::ST_PAUSE && pause_done && en_ok
                                  |=> state_r == cpg_pkg::ST_SOFT)
    else $error("pause did not end in soft start");
  AST_RETRY_HOLD: assert property (rd_status && overload && retry_flag_r |=> retry_flag_r)
    else $error("retry flag cleared under overload");
  AST_CURRENT_LIMIT_FLAG_SET: assert property (!ctrl_r.retry && sw_tick && lim_now && consec_r == 6'(FLAG_CYCLES - 1)
                                 |=> current_limit_flag_flag_r)
    else $error("limit flag not set");
  AST_CURRENT_LIMIT_FLAG_HOLD: assert property (rd_status && overload && current_limit_flag_flag_r |=> current_limit_flag_flag_r)
    else $error("limit flag cleared under overload");
  AST_DEGLITCH: assert property ($rose(filt_r) |-> $past(glitch_cnt_r) == 9'(DEGLITCH_CYCLES - 1))
    else $error("deglitch interval wrong");
  AST_GOOD_LOW: assert property (!ctrl_r.second && (!filt_r || !good_raw) |=> !good_oe_n)
    else $error("good released out of window");
  AST_GOOD_FORCE: assert property (forced_low |=> !good_oe_n)
    else $error("good not forced low");

endmodule

// file: verif/cpg_partner.sv
// behavioural model of comparators, switching clock and soft-start core beside the block
`timescale 1ns/10ps

module cpg_partner (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  // bench requests
  input  wire logic                   overload,
  input  wire cpg_pkg::cpg_sense_type pins,
  // block side
  input  wire cpg_pkg::cpg_drive_type drive,
  output cpg_pkg::cpg_sense_type      sense,
  output logic                        sw_tick,
  output logic                        softstart_done
);
  logic [1:0] tick_cnt_r;
  logic [4:0] ss_cnt_r;

  // current falls below low-side limit once the overload goes
  always_comb begin
    sense          = pins;
    sense.hs_over  = overload;
    sense.ls_below = !overload;
  end

  // switching cycle of four clocks
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_r <= 2'h0;
      sw_tick    <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 2'h1;
      sw_tick    <= (tick_cnt_r == 2'h3);
    end
  end

  // soft start takes twenty-one clocks, restarted by each go pulse
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ss_cnt_r       <= 5'h00;
      softstart_done <= 1'b0;
    end else if (!drive.switching_run || drive.softstart_go) begin
      ss_cnt_r       <= 5'h00;
      softstart_done <= 1'b0;
    end else if (ss_cnt_r == 5'h14) begin
      softstart_done <= 1'b1;
    end else begin
      ss_cnt_r <= ss_cnt_r + 5'h01;
    end
  end
endmodule

// file: verif/testbench.sv
// self-checking bench of the protection and power-good block
`timescale 1ns/10ps

module testbench;
  localparam int DG = 10;
  logic                   clk_sys, rstn, hsel, hwrite, hready, hreadyout, hresp, sw_tick, softstart_done;
  logic                   ramp_active, ccm_mode, good_out, good_oe_n, overload;
  logic [31:0]            haddr, hwdata, hrdata, rd;
  logic [1:0]             htrans;
  logic [2:0]             hsize;
  cpg_pkg::cpg_sense_type pins, sense;
  cpg_pkg::cpg_drive_type drive;
  int                     n_fail, num_checks, cyc, i, n;

  assign hready = hreadyout;

  cpg_top #(.PAUSE_CYCLES(8), .TRIP_CYCLES(4), .FLAG_CYCLES(4), .DEGLITCH_CYCLES(DG)) DUT (
    .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sense(sense), .sw_tick(sw_tick), .softstart_done(softstart_done),
    .ramp_active(ramp_active), .drive(drive), .ccm_mode(ccm_mode), .good_in(good_oe_n),
    .good_out(good_out), .good_oe_n(good_oe_n));

  cpg_partner partner (.clk_sys(clk_sys), .rstn(rstn), .overload(overload), .pins(pins),
    .drive(drive), .sense(sense), .sw_tick(sw_tick), .softstart_done(softstart_done));

  // clock of 100 ns
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // single word transfer, entered just after a rising edge
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  // read until the masked field matches or the tries run out
  task automatic poll(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp, input int tries);
    for (int k = 0; k < tries; k++) begin
      ahb(1'b0, a, 32'h0);
      if ((rd & m) === exp) break;
    end
    chk(rd & m, exp);
  endtask

  task automatic cycles(input int c);
    repeat (c) @(posedge clk_sys);
  endtask

  initial begin
    void'($urandom(14));
    {rstn, hsel, hwrite, overload, ramp_active} = 5'h00;
    {haddr, hwdata} = 64'h0;
    htrans = 2'b00;
    hsize = 3'h2;
    pins = 8'h10;
    cycles(4);
    rstn <= 1'b1;
    cycles(2);
    poll(32'h00, 32'hffffffff, 32'h03, 1);                          // reset value
    poll(32'h08, 32'h7, 32'h0, 1);                                   // off, good low
    chk(drive.discharge_on, 1'b0);                                   // not yet enabled
    chk({hreadyout, hresp, good_out, ccm_mode}, 4'h9);               // primary, bus okay
    ahb(1'b1, 32'h0c, $urandom);
    poll(32'h0c, 32'hffffffff, 32'h0, 1);
    // first start
    pins.en_pin <= 1'b1;
    for (i = 0; i < 20 && drive.softstart_go !== 1'b1; i++) cycles(1);
    chk(drive.softstart_go, 1'b1);
    poll(32'h08, 32'h7, 32'h1, 4);                                   // low in soft start
    poll(32'h08, 32'h3, 32'h3, 30);
    for (n = 0; n < 50 && good_oe_n !== 1'b1; n++) cycles(1);
    chk(n >= DG - 6 && n <= DG + 2, 1'b1);                           // deglitched release
    // window and blanking
    pins.out_window <= 1'b1;
    cycles(5);
    chk(good_oe_n, 1'b0);                                            // out of window
    ramp_active <= 1'b1;
    ahb(1'b1, 32'h00, 32'h0b);
    cycles(DG + 8);
    chk(good_oe_n, 1'b1);                                            // blanked ramp
    ramp_active <= 1'b0;
    cycles(3);
    chk(good_oe_n, 1'b0);                                            // blanking ends
    pins.out_window <= 1'b0;
    ahb(1'b1, 32'h00, 32'h03);
    // plain current limit
    overload <= 1'b1;
    cycles(6);
    chk({drive.hs_allow, drive.ls_force}, 2'b01);                    // low side on
    cycles(18);
    poll(32'h04, 32'h3, 32'h2, 1);                                   // limit flag
    poll(32'h04, 32'h3, 32'h2, 1);                                   // kept in overload
    poll(32'h08, 32'h3, 32'h3, 1);                                   // no retry
    overload <= 1'b0;
    cycles(12);
    chk({drive.hs_allow, drive.ls_force}, 2'b10);                    // high side back
    poll(32'h04, 32'h3, 32'h2, 1);                                   // read clears
    poll(32'h04, 32'h3, 32'h0, 1);                                   // now clear
    // retry protection
    ahb(1'b1, 32'h00, 32'h07);
    overload <= 1'b1;
    poll(32'h08, 32'h7, 32'h2, 40);                                  // pause, good low
    chk(drive.switching_run, 1'b0);                                  // switching halted
    poll(32'h04, 32'h1, 32'h1, 1);                                   // event flag
    poll(32'h04, 32'h1, 32'h1, 1);                                   // kept in overload
    poll(32'h08, 32'h3, 32'h1, 40);                                  // new soft start
    for (i = 0; i < 200 && drive.switching_run !== 1'b0; i++) cycles(1);
    for (n = 0; n < 200 && drive.switching_run !== 1'b1; n++) cycles(1);
    chk(n >= 28 && n <= 36, 1'b1);                                   // pause of eight ticks
    overload <= 1'b0;
    poll(32'h08, 32'h7, 32'h7, 100);                                 // good again
    poll(32'h04, 32'h1, 32'h1, 1);                                   // read clears
    poll(32'h04, 32'h1, 32'h0, 1);                                   // now clear
    // control bits
    ahb(1'b1, 32'h00, 32'h01);
    cycles(4);
    chk({drive.switching_run, drive.discharge_on}, 2'b01);           // switching off
    ahb(1'b1, 32'h00, 32'h00);
    cycles(4);
    chk(drive.discharge_on, 1'b0);                                   // discharge off
    ahb(1'b1, 32'h00, 32'h03);
    poll(32'h08, 32'h3, 32'h3, 40);
    // lockouts and shutdown
    pins.supply_low <= 1'b1;
    cycles(6);
    chk({drive.switching_run, drive.discharge_on, good_oe_n}, 3'b010); // low lockout
    pins.supply_low <= 1'b0;
    poll(32'h08, 32'h3, 32'h3, 40);
    pins.supply_high  <= 1'b1;
    pins.supply_ok_hi <= 1'b0;
    cycles(6);
    chk({drive.switching_run, drive.discharge_on}, 2'b01);           // high lockout
    pins.supply_high <= 1'b0;
    cycles(8);
    chk(drive.switching_run, 1'b0);                                  // held above release
    pins.supply_ok_hi <= 1'b1;
    for (i = 0; i < 20 && drive.softstart_go !== 1'b1; i++) cycles(1);
    chk(drive.softstart_go, 1'b1);                                   // fresh soft start
    pins.thermal_shut <= 1'b1;
    cycles(6);
    chk({drive.discharge_on, good_oe_n}, 2'b10);                     // shutdown
    ahb(1'b1, 32'h00, 32'h13);
    cycles(4);
    chk(ccm_mode, 1'b0);                                             // secondary starts discontinuous
    pins.thermal_shut <= 1'b0;
    poll(32'h08, 32'h3, 32'h3, 40);
    cycles(6);
    chk({ccm_mode, good_oe_n, good_out}, 3'b110);                    // shared pin rose, continuous
    finish_test();
  end
endmodule
